// [bbrc_regs.sv]
// APB register bank and analog control outputs of the buck second half
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ns
module bbrc_regs #(
  parameter int ADDR_W = 12
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [ADDR_W-1:0]          paddr,
  input  wire logic [31:0]                pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       cfg_load,
  input  wire logic                       cfg_range,
  input  wire bbrc_pkg::bbrc_pwr_e        pwr_state,
  input  wire logic                       combined_phase,
  input  wire bbrc_pkg::bbrc_first_half_s first_half,
  output bbrc_pkg::bbrc_analog_s          analog_ctrl
);

  // Index bits sit above the byte offset, nothing may sit above them
  localparam int UPPER_LSB = bbrc_pkg::IDX_SHIFT + bbrc_pkg::REG_W;
  localparam int ADDR_MIN  = UPPER_LSB - 1;
  localparam int ADDR_MAX  = 32;
  localparam int IDX_W     = bbrc_pkg::REG_W;

  // Address must reach the highest register index
  generate
    if (ADDR_W < ADDR_MIN || ADDR_W > ADDR_MAX) begin : g_bad_addr_w
      $error("bbrc_regs: ADDR_W must be between 9 and 32");
    end
  endgenerate

  // Stored register bytes and the configured range
  logic [7:0]  normal_q;
  logic [7:0]  standby_q;
  logic [7:0]  sleep_q;
  logic [7:0]  mode_q;
  logic [7:0]  conf_q;
  logic        range_reg;

  // Address decode, bus phases and write strobes
  logic [7:0]  reg_index;
  logic        word_aligned;
  logic        upper_zero;
  logic        hit_normal;
  logic        hit_standby;
  logic        hit_sleep;
  logic        hit_mode;
  logic        hit_conf;
  logic        hit_status;
  logic        mapped;
  logic        setup_phase;
  logic        access_phase;
  logic        wr_fire;
  logic        lane0;
  logic        wr_normal;
  logic        wr_standby;
  logic        wr_sleep;
  logic        wr_mode;
  logic        wr_conf;

  // Read path
  logic [5:0]  sel_code;
  logic        sel_range;
  logic [7:0]  status_q;
  logic [7:0]  rd_byte;
  logic [31:0] prdata_next;
  logic        pslverr_next;

  // Output stage towards the regulator
  logic        in_sleep;
  logic [5:0]  level_out_reg;
  logic        range_out_reg;
  logic [3:0]  mode_out_reg;
  logic        enable_out_reg;
  logic        pulse_out_reg;
  logic        limit_out_reg;
  logic [1:0]  freq_out_reg;
  logic [1:0]  phase_out_reg;
  logic [1:0]  slew_out_reg;

  // Index is the byte address divided by four
  assign word_aligned = (paddr[bbrc_pkg::IDX_SHIFT-1:0] == 2'b00);
  generate
    if (ADDR_W > UPPER_LSB) begin : g_upper
      assign reg_index  = paddr[bbrc_pkg::IDX_SHIFT +: IDX_W];
      assign upper_zero = (paddr[ADDR_W-1:UPPER_LSB] == '0);
    end else begin : g_noupper
      assign reg_index  = IDX_W'(paddr[ADDR_W-1:bbrc_pkg::IDX_SHIFT]); // Short bus, top index bits zero
      assign upper_zero = 1'b1;
    end
  endgenerate

  // Address decode of every register
  assign hit_normal  = word_aligned && upper_zero && (reg_index == bbrc_pkg::IDX_NORMAL);
  assign hit_standby = word_aligned && upper_zero && (reg_index == bbrc_pkg::IDX_STANDBY);
  assign hit_sleep   = word_aligned && upper_zero && (reg_index == bbrc_pkg::IDX_SLEEP);
  assign hit_mode    = word_aligned && upper_zero && (reg_index == bbrc_pkg::IDX_MODE);
  assign hit_conf    = word_aligned && upper_zero && (reg_index == bbrc_pkg::IDX_CONF);
  assign hit_status  = word_aligned && upper_zero && (reg_index == bbrc_pkg::IDX_STATUS);
  assign mapped      = hit_normal | hit_standby | hit_sleep | hit_mode | hit_conf | hit_status;

  // Transfer phases of the bus
  assign setup_phase  = psel && !penable;
  assign access_phase = psel && penable;
  assign lane0        = pstrb[0];
  assign wr_fire      = access_phase && pwrite && lane0 && mapped;

  // Zero wait states, answer in the first access cycle
  assign pready = access_phase;

  // Write strobe of each stored register
  assign wr_normal  = wr_fire && hit_normal;
  assign wr_standby = wr_fire && hit_standby;
  assign wr_sleep   = wr_fire && hit_sleep;
  assign wr_mode    = wr_fire && hit_mode;
  assign wr_conf    = wr_fire && hit_conf;

  // Normal set-point, only the level code is writable
  bbrc_field_reg #(
    .RESET_VAL (bbrc_pkg::LEVEL_RESET),
    .WMASK     (bbrc_pkg::LEVEL_WMASK)
  ) u_normal (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_normal),
    .wr_data (pwdata[7:0]),
    .q       (normal_q)
  );

  // Standby set-point
  bbrc_field_reg #(
    .RESET_VAL (bbrc_pkg::LEVEL_RESET),
    .WMASK     (bbrc_pkg::LEVEL_WMASK)
  ) u_standby (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_standby),
    .wr_data (pwdata[7:0]),
    .q       (standby_q)
  );

  // Sleep set-point
  bbrc_field_reg #(
    .RESET_VAL (bbrc_pkg::LEVEL_RESET),
    .WMASK     (bbrc_pkg::LEVEL_WMASK)
  ) u_sleep (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_sleep),
    .wr_data (pwdata[7:0]),
    .q       (sleep_q)
  );

  // Switching mode and sleep behaviour
  bbrc_field_reg #(
    .RESET_VAL (bbrc_pkg::MODE_RESET),
    .WMASK     (bbrc_pkg::MODE_WMASK)
  ) u_mode (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_mode),
    .wr_data (pwdata[7:0]),
    .q       (mode_q)
  );

  // Current limit, frequency, phase and slew
  bbrc_field_reg #(
    .RESET_VAL (bbrc_pkg::CONF_RESET),
    .WMASK     (bbrc_pkg::CONF_WMASK)
  ) u_conf (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_conf),
    .wr_data (pwdata[7:0]),
    .q       (conf_q)
  );

  // Range bit, changed by configuration load only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      range_reg <= bbrc_pkg::RANGE_RESET;
    end else if (cfg_load) begin
      range_reg <= cfg_range;
    end
  end

  // Active set-point by power state and phase arrangement
  bbrc_level_sel u_level_sel (
    .pclk           (pclk),
    .presetn        (presetn),
    .pwr_state      (pwr_state),
    .combined_phase (combined_phase),
    .normal_code    (normal_q[bbrc_pkg::LEVEL_LSB +: bbrc_pkg::LEVEL_W]),
    .standby_code   (standby_q[bbrc_pkg::LEVEL_LSB +: bbrc_pkg::LEVEL_W]),
    .sleep_code     (sleep_q[bbrc_pkg::LEVEL_LSB +: bbrc_pkg::LEVEL_W]),
    .range_bit      (range_reg),
    .first_half     (first_half),
    .level_code     (sel_code),
    .level_range    (sel_range)
  );

  // Status byte: active code and arrangement
  always_comb begin
    status_q                                        = 8'h00;
    status_q[bbrc_pkg::LEVEL_LSB +: bbrc_pkg::LEVEL_W] = sel_code;
    status_q[bbrc_pkg::RANGE_BIT]                   = sel_range;
    status_q[bbrc_pkg::REG_W-1]                     = combined_phase;
  end

  // Read value of the addressed register
  always_comb begin
    rd_byte = 8'h00;
    case (1'b1)
      hit_normal: begin
        rd_byte                          = normal_q;
        rd_byte[bbrc_pkg::RANGE_BIT]     = range_reg;
      end
      hit_standby: begin
        rd_byte                          = standby_q;
        rd_byte[bbrc_pkg::RANGE_BIT]     = range_reg;
      end
      hit_sleep: begin
        rd_byte                          = sleep_q;
        rd_byte[bbrc_pkg::RANGE_BIT]     = range_reg;
      end
      hit_mode: begin
        rd_byte = mode_q & bbrc_pkg::MODE_WMASK;
      end
      hit_conf: begin
        rd_byte = conf_q & bbrc_pkg::CONF_WMASK;
      end
      hit_status: begin
        rd_byte = status_q;
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // Upper bytes read as zero
  always_comb begin
    prdata_next       = bbrc_pkg::RDATA_ZERO;
    prdata_next[7:0]  = rd_byte;
    pslverr_next      = !mapped;
  end

  // Read data and error captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= bbrc_pkg::RDATA_ZERO;
    end else if (setup_phase) begin
      prdata <= pwrite ? bbrc_pkg::RDATA_ZERO : prdata_next;
    end
  end

  // Error flag for unmapped addresses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      pslverr <= pslverr_next;
    end else if (!psel) begin
      pslverr <= 1'b0;
    end
  end

  // Sleep decides between off and pulse-frequency operation
  assign in_sleep = (pwr_state == bbrc_pkg::BBRC_PWR_SLEEP);

  // Active set-point code towards the regulator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_out_reg <= '0;
    end else begin
      level_out_reg <= sel_code;
    end
  end

  // Active range towards the regulator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      range_out_reg <= bbrc_pkg::RANGE_RESET;
    end else begin
      range_out_reg <= sel_range;
    end
  end

  // Switching operation mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_out_reg <= '0;
    end else begin
      mode_out_reg <= mode_q[bbrc_pkg::MODE_LSB +: bbrc_pkg::MODE_W];
    end
  end

  // Sleep behaviour, output off or pulse-frequency operation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_out_reg <= 1'b0;
      pulse_out_reg  <= 1'b0;
    end else begin
      enable_out_reg <= !(in_sleep && !mode_q[bbrc_pkg::SLEEPB_BIT]);
      pulse_out_reg  <= in_sleep && mode_q[bbrc_pkg::SLEEPB_BIT];
    end
  end

  // Current limit level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limit_out_reg <= 1'b0;
    end else begin
      limit_out_reg <= conf_q[bbrc_pkg::ILIM_BIT];
    end
  end

  // Frequency, clock phase and slew speed selections
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_out_reg  <= '0;
      phase_out_reg <= '0;
      slew_out_reg  <= '0;
    end else begin
      freq_out_reg  <= conf_q[bbrc_pkg::FREQ_LSB +: bbrc_pkg::SEL_W];
      phase_out_reg <= conf_q[bbrc_pkg::PHASE_LSB +: bbrc_pkg::SEL_W];
      slew_out_reg  <= conf_q[bbrc_pkg::SLEW_LSB +: bbrc_pkg::SEL_W];
    end
  end

  // Flopped controls gathered into the bundle for the regulator
  always_comb begin
    analog_ctrl.level_code                = level_out_reg;
    analog_ctrl.range_bit                 = range_out_reg;
    analog_ctrl.switch_mode_code          = mode_out_reg;
    analog_ctrl.output_enable             = enable_out_reg;
    analog_ctrl.pulse_frequency_operation = pulse_out_reg;
    analog_ctrl.current_limit_level       = limit_out_reg;
    analog_ctrl.switch_frequency_code     = freq_out_reg;
    analog_ctrl.clock_phase_code          = phase_out_reg;
    analog_ctrl.slew_speed_code           = slew_out_reg;
  end

endmodule : bbrc_regs

// [bbrc_pkg.sv]
// Package with constants, types and carriers of the buck second-half config registers
// Operation
// - Normal set-point bits 5:0 give the output code in normal operation.
// - Normal set-point bit 6 is read-only range, set only by configuration load.
// - Standby set-point bits 5:0 give the output code in standby.
// - Standby register range bit mirrors the loaded normal range bit.
// - Sleep set-point bits 5:0 give the output code in sleep.
// - Sleep register range bit mirrors the loaded normal range bit.
// - Mode register bits 3:0 select the switching operation mode.
// - Mode register bit 5 chooses sleep behaviour: zero off, one pulse-frequency.
// - Config bit 0 selects current limit: zero high level, one low level.
// - Config bits 3:2 select the switching frequency.
// - Config bits 5:4 select the switching clock phase.
// - Config bits 7:6 select the voltage scaling slew speed.
// - In combined single-phase use the first half's set-points drive the output.
package bbrc_pkg;

  // Register indices, byte address is four times the index
  localparam logic [7:0] IDX_NORMAL  = 8'h43;
  localparam logic [7:0] IDX_STANDBY = 8'h44;
  localparam logic [7:0] IDX_SLEEP   = 8'h45;
  localparam logic [7:0] IDX_MODE    = 8'h46;
  localparam logic [7:0] IDX_CONF    = 8'h47;
  localparam logic [7:0] IDX_STATUS  = 8'h48;
  localparam int         IDX_SHIFT   = 2;

  // Field positions
  localparam int LEVEL_LSB  = 0;
  localparam int LEVEL_W    = 6;
  localparam int RANGE_BIT  = 6;
  localparam int MODE_LSB   = 0;
  localparam int MODE_W     = 4;
  localparam int SLEEPB_BIT = 5;
  localparam int ILIM_BIT   = 0;
  localparam int FREQ_LSB   = 2;
  localparam int PHASE_LSB  = 4;
  localparam int SLEW_LSB   = 6;
  localparam int SEL_W      = 2;
  localparam int REG_W      = 8;

  // Writable masks and reset values
  localparam logic [7:0] LEVEL_WMASK = 8'h3f;
  localparam logic [7:0] MODE_WMASK  = 8'h2f;
  localparam logic [7:0] CONF_WMASK  = 8'hfd;
  localparam logic [7:0] LEVEL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET  = 8'h00;
  localparam logic [7:0] CONF_RESET  = 8'h00;
  localparam logic       RANGE_RESET = 1'b0;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

  // Power states of the regulator
  typedef enum logic [1:0] {
    BBRC_PWR_NORMAL,
    BBRC_PWR_STANDBY,
    BBRC_PWR_SLEEP
  } bbrc_pwr_e;

  // First-half set-points used when both halves combine
  typedef struct packed {
    logic [5:0] normal_code;
    logic [5:0] standby_code;
    logic [5:0] sleep_code;
    logic       range_bit;
  } bbrc_first_half_s;

  // Analog control bundle for the second half
  typedef struct packed {
    logic [5:0] level_code;
    logic       range_bit;
    logic [3:0] switch_mode_code;
    logic       output_enable;
    logic       pulse_frequency_operation;
    logic       current_limit_level;
    logic [1:0] switch_frequency_code;
    logic [1:0] clock_phase_code;
    logic [1:0] slew_speed_code;
  } bbrc_analog_s;

endpackage : bbrc_pkg

// [bbrc_field_reg.sv]
// One byte-wide register with per-bit write mask and reset value
`timescale 1ns/1ns
module bbrc_field_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WMASK     = 8'hff
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] q
);

  // Only masked bits take write data, others keep reset value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= RESET_VAL;
    end else if (wr_en) begin
      q <= (q & ~WMASK) | (wr_data & WMASK);
    end
  end

endmodule : bbrc_field_reg

// [bbrc_level_sel.sv]
// Selects the active set-point code by power state and phase arrangement
`timescale 1ns/1ns
module bbrc_level_sel (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire bbrc_pkg::bbrc_pwr_e       pwr_state,
  input  wire logic                      combined_phase,
  input  wire logic [5:0]                normal_code,
  input  wire logic [5:0]                standby_code,
  input  wire logic [5:0]                sleep_code,
  input  wire logic                      range_bit,
  input  wire bbrc_pkg::bbrc_first_half_s first_half,
  output logic      [5:0]                level_code,
  output logic                           level_range
);

  logic [5:0] own_code;
  logic [5:0] first_code;

  // Code of the current power state for each half
  always_comb begin
    own_code   = normal_code;
    first_code = first_half.normal_code;
    case (pwr_state)
      bbrc_pkg::BBRC_PWR_NORMAL: begin
        own_code   = normal_code;
        first_code = first_half.normal_code;
      end
      bbrc_pkg::BBRC_PWR_STANDBY: begin
        own_code   = standby_code;
        first_code = first_half.standby_code;
      end
      bbrc_pkg::BBRC_PWR_SLEEP: begin
        own_code   = sleep_code;
        first_code = first_half.sleep_code;
      end
      default: begin
        own_code   = normal_code;
        first_code = first_half.normal_code;
      end
    endcase
  end

  // Registered choice, first half wins when combined
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_code  <= '0;
      level_range <= bbrc_pkg::RANGE_RESET;
    end else if (combined_phase) begin
      level_code  <= first_code;
      level_range <= first_half.range_bit;
    end else begin
      level_code  <= own_code;
      level_range <= range_bit;
    end
  end

endmodule : bbrc_level_sel

// [bbrc_regs_properties.sv]
// Concurrent checks on the ports of the buck second-half config register bank
`timescale 1ns/1ns
module bbrc_regs_properties #(
  parameter int ADDR_W = 12
) (
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [ADDR_W-1:0]          paddr,
  input wire logic [31:0]                pwdata,
  input wire logic [3:0]                 pstrb,
  input wire logic [31:0]                prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire logic                       cfg_load,
  input wire logic                       cfg_range,
  input wire bbrc_pkg::bbrc_pwr_e        pwr_state,
  input wire logic                       combined_phase,
  input wire bbrc_pkg::bbrc_first_half_s first_half,
  input wire bbrc_pkg::bbrc_analog_s     analog_ctrl
);
  localparam int A_NORM = 'h10c;
  localparam int A_STBY = 'h110;
  localparam int A_SLP  = 'h114;
  localparam int A_MODE = 'h118;
  localparam int A_CONF = 'h11c;
  localparam int A_STAT = 'h120;
  logic wr;
  logic bad_addr;

  // Write commit and unmapped place decode
  assign wr       = psel && penable && pwrite && pstrb[0];
  assign bad_addr = paddr[1:0] != 2'd0 || paddr < A_NORM || paddr > A_STAT;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  mode_write_a: assert property (wr && paddr == A_MODE |=> ##1
    analog_ctrl.switch_mode_code == $past(pwdata[3:0], 2)) else $error("mode code not applied");
  conf_write_a: assert property (wr && paddr == A_CONF |=> ##1
    {analog_ctrl.slew_speed_code, analog_ctrl.clock_phase_code, analog_ctrl.switch_frequency_code,
     analog_ctrl.current_limit_level} == {$past(pwdata[7:2], 2), $past(pwdata[0], 2)})
    else $error("tuning not applied");
  norm_level_a: assert property (wr && paddr == A_NORM ##1
    (pwr_state == bbrc_pkg::BBRC_PWR_NORMAL && !combined_phase) |=>
    ##1 analog_ctrl.level_code == $past(pwdata[5:0], 3)) else $error("normal code not applied");
  stby_level_a: assert property (wr && paddr == A_STBY ##1
    (pwr_state == bbrc_pkg::BBRC_PWR_STANDBY && !combined_phase) |=>
    ##1 analog_ctrl.level_code == $past(pwdata[5:0], 3)) else $error("standby code not applied");
  sleep_level_a: assert property (wr && paddr == A_SLP ##1
    (pwr_state == bbrc_pkg::BBRC_PWR_SLEEP && !combined_phase) |=>
    ##1 analog_ctrl.level_code == $past(pwdata[5:0], 3)) else $error("sleep code not applied");
  sleep_out_a: assert property ((pwr_state == bbrc_pkg::BBRC_PWR_SLEEP) [*4] |->
    analog_ctrl.output_enable == analog_ctrl.pulse_frequency_operation) else $error("sleep behaviour wrong");
  awake_out_a: assert property ((pwr_state != bbrc_pkg::BBRC_PWR_SLEEP) [*4] |->
    analog_ctrl.output_enable && !analog_ctrl.pulse_frequency_operation) else $error("awake output wrong");
  join_level_a: assert property ((combined_phase && pwr_state == bbrc_pkg::BBRC_PWR_NORMAL &&
    $stable(first_half)) [*3] |-> analog_ctrl.level_code == first_half.normal_code) else $error("joined code wrong");
  bad_place_a: assert property (psel && !penable |=>
    pslverr == $past(bad_addr)) else $error("error response wrong");
  rdata_top_a: assert property (psel && penable |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
endmodule : bbrc_regs_properties

bind bbrc_regs bbrc_regs_properties #(.ADDR_W(ADDR_W)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cfg_load(cfg_load), .cfg_range(cfg_range), .pwr_state(pwr_state), .combined_phase(combined_phase),
  .first_half(first_half), .analog_ctrl(analog_ctrl)
);

// [bbrc_regs_tb_top.sv]
// Self-checking bench of the buck second-half config register bank
`timescale 1ns/1ns
module bbrc_regs_tb_top;
  logic                       pclk           = 1'b0;
  logic                       presetn        = 1'b0;
  logic                       psel           = 1'b0;
  logic                       penable        = 1'b0;
  logic                       pwrite         = 1'b0;
  logic [11:0]                paddr          = 12'h000;
  logic [31:0]                pwdata         = 32'h0000_0000;
  logic [3:0]                 pstrb          = 4'hf;
  logic [31:0]                prdata;
  logic                       pready;
  logic                       pslverr;
  logic                       cfg_load       = 1'b0;
  logic                       cfg_range      = 1'b0;
  bbrc_pkg::bbrc_pwr_e        pwr_state      = bbrc_pkg::BBRC_PWR_NORMAL;
  logic                       combined_phase = 1'b0;
  bbrc_pkg::bbrc_first_half_s first_half     = '0;
  bbrc_pkg::bbrc_analog_s     analog_ctrl;
  int                         n_errors       = 0;
  int                         total_checks   = 0;
  logic [31:0]                lfsr_q         = 32'h0000_782b;
  logic [7:0]                 mdl [5];
  logic                       rng            = 1'b0;
  logic [31:0]                rd;
  logic                       err;

  bbrc_regs #(.ADDR_W(12)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cfg_load(cfg_load), .cfg_range(cfg_range), .pwr_state(pwr_state), .combined_phase(combined_phase),
    .first_half(first_half), .analog_ctrl(analog_ctrl)
  );

  // Clock of 20 ns
  always #10 pclk = ~pclk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [11:0] addr(input int i);
    return 12'h10c + 12'(4 * i);
  endfunction : addr

  // Expected read value of a register
  function automatic logic [31:0] exp_rd(input int i);
    if (i < 3) return {24'h0, mdl[i] | {1'b0, rng, 6'h00}};
    return {24'h0, mdl[i]};
  endfunction : exp_rd

  // Expected analog control bundle
  function automatic bbrc_pkg::bbrc_analog_s exp_an();
    bbrc_pkg::bbrc_analog_s a;
    logic                   slp;
    slp = (pwr_state == bbrc_pkg::BBRC_PWR_SLEEP);
    a.level_code = mdl[pwr_state][5:0];
    if (combined_phase) a.level_code = slp ? first_half.sleep_code :
      (pwr_state == bbrc_pkg::BBRC_PWR_STANDBY ? first_half.standby_code : first_half.normal_code);
    a.range_bit                 = combined_phase ? first_half.range_bit : rng;
    a.switch_mode_code          = mdl[3][3:0];
    a.output_enable             = !(slp && !mdl[3][5]);
    a.pulse_frequency_operation = slp && mdl[3][5];
    a.current_limit_level       = mdl[4][0];
    a.switch_frequency_code     = mdl[4][3:2];
    a.clock_phase_code          = mdl[4][5:4];
    a.slew_speed_code           = mdl[4][7:6];
    return a;
  endfunction : exp_an

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic give_verdict();
    if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  // One APB transfer, waits for pready under a bound
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) n_errors++;
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Main sequence
  initial begin
    for (int i = 0; i < 5; i++) mdl[i] = 8'h00;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, addr(i), 32'h0);
      chk(rd, 32'h0);
    end
    for (int r = 0; r < 12; r++) begin
      @(posedge pclk);
      lfsr_q = lfsr(lfsr_q);
      pwr_state      <= bbrc_pkg::bbrc_pwr_e'(r % 3);
      combined_phase <= (r % 4 == 3);
      first_half     <= lfsr_q[18:0];
      cfg_load       <= r[0];
      cfg_range      <= r[1];
      @(posedge pclk);
      cfg_load <= 1'b0;
      if (r[0]) rng = r[1];
      for (int i = 0; i < 5; i++) begin
        lfsr_q = lfsr(lfsr_q);
        if (i == 3) lfsr_q[5] = r[1];
        apb(1'b1, addr(i), lfsr_q);
        mdl[i] = lfsr_q[7:0] & (i < 3 ? 8'h3f : (i == 3 ? 8'h2f : 8'hfd));
      end
      for (int i = 0; i < 5; i++) begin
        apb(1'b0, addr(i), 32'h0);
        chk(rd, exp_rd(i));
      end
      apb(1'b0, addr(5), 32'h0);
      chk(rd, {24'h0, combined_phase, exp_an().range_bit, exp_an().level_code});
      repeat (2) @(posedge pclk);
      chk({12'h0, analog_ctrl}, {12'h0, exp_an()});
    end
    // Refused writes and unmapped places
    @(posedge pclk);
    pstrb <= 4'he;
    apb(1'b1, addr(4), 32'h0000_00ff);
    pstrb <= 4'hf;
    apb(1'b0, addr(4), 32'h0);
    chk(rd, exp_rd(4));
    apb(1'b0, 12'h124, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, 12'h10d, 32'h0000_003f);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, addr(0), 32'h0);
    chk(rd, exp_rd(0));
    give_verdict();
  end

  // Watchdog against a hang
  initial begin
    #200000;
    n_errors++;
    give_verdict();
  end
endmodule : bbrc_regs_tb_top
